// *** rtl/axis_frame_pkg.sv ***
// Constants shared by the framing user port: block codes, timing counts and register map.
package axis_frame_pkg;
	// Lane geometry.
	localparam int LANE_BYTES = 8;
	localparam int LANE_BITS = 64;
	// Two-bit sync headers that precede every 64-bit block.
	localparam logic [1:0] HDR_DATA = 2'h1;
	localparam logic [1:0] HDR_CTRL = 2'h2;
	// Control block type bytes, carried in byte 0 of a control block.
	localparam logic [7:0] BLK_END = 8'h1e;
	localparam logic [7:0] BLK_END7 = 8'he1;
	localparam logic [7:0] BLK_IDLE = 8'h78;
	localparam logic [7:0] BLK_CC = 8'h55;
	// Largest byte count that fits behind the type and count bytes of an end block.
	localparam int END_MAX_BYTES = 6;
	// Gearbox pause period and clock compensation timing, in user clock cycles.
	localparam int GB_PERIOD = 32;
	localparam int CC_HOLD = 8;
	localparam int CC_BLOCKS = 3;
	localparam int CC_PERIOD_DEFAULT = 10000;
	// Register byte offsets.
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_TX_FRAMES = 8'h08;
	localparam logic [7:0] REG_RX_FRAMES = 8'h0c;
	// Control fields and reset value.
	localparam int CTRL_TX_EN = 0;
	localparam int CTRL_RX_EN = 1;
	localparam logic [31:0] CTRL_RESET = 32'h00000003;
	// Status fields.
	localparam int STAT_UP = 0;
	localparam int STAT_TX_OPEN = 1;
	localparam int STAT_RX_OPEN = 2;
	localparam int STAT_CC = 3;
	localparam int STAT_END_PEND = 4;
endpackage : axis_frame_pkg

// *** rtl/axis_frame_user_port.sv ***
// Framing user port: stream handshake to 66-bit lane blocks and back, with an APB register slave.
`timescale 1ns/1ps
module axis_frame_user_port
	import axis_frame_pkg::*;
#(
	parameter int LANES = 1,
	parameter int CC_PERIOD = CC_PERIOD_DEFAULT,
	parameter int APB_AW = 8
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic channel_up,
	input wire logic xcvr_gearbox_slot_ok,
	input wire logic [64*LANES-1:0] tx_tdata,
	input wire logic tx_tvalid,
	input wire logic tx_tlast,
	input wire logic [8*LANES-1:0] tx_tkeep,
	output logic tx_tready,
	output logic [64*LANES-1:0] tx_blk_data,
	output logic [2*LANES-1:0] tx_blk_hdr,
	output logic tx_blk_valid,
	input wire logic [64*LANES-1:0] rx_blk_data,
	input wire logic [2*LANES-1:0] rx_blk_hdr,
	input wire logic rx_blk_valid,
	output logic [64*LANES-1:0] rx_tdata,
	output logic rx_tvalid,
	output logic rx_tlast,
	output logic [8*LANES-1:0] rx_tkeep,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr
);
	// Derived sizes: bytes per word, the width of a byte count and the timer widths.
	localparam int WB = 8 * LANES;
	localparam int NBW = $clog2(WB + 1);
	localparam int GBW = $clog2(GB_PERIOD);
	localparam int CCW = $clog2(CC_PERIOD);
	localparam int CHW = $clog2(CC_HOLD + 1);

	// State shared by the transmit pacing, the receive hold stage and the registers.
	// Every output below is taken from one of these flops, never from a gate.
	logic [31:0] ctrl;
	logic [31:0] tx_frames;
	logic [31:0] rx_frames;
	logic [GBW-1:0] gb_cnt;
	logic gb_pause;
	logic [CCW-1:0] cc_timer;
	logic [CHW-1:0] cc_cnt;
	logic end_pend;
	logic tx_open;
	logic rx_open;
	logic [64*LANES-1:0] hold_data;
	logic [NBW-1:0] hold_bytes;
	logic hold_valid;
	logic hold_last;
	logic [NBW-1:0] tx_nbytes;
	logic [NBW-1:0] cur_bytes;
	logic [64*LANES-1:0] next_blk_data;
	logic [2*LANES-1:0] next_blk_hdr;
	logic [64*LANES-1:0] cur_data;
	logic [LANES-1:0] lane_end;
	logic [4*LANES-1:0] lane_cnt;
	logic [WB-1:0] next_rx_keep;

	// Transmit pacing: the gearbox pause, clock compensation and a deferred end block all stall.
	// Ready is registered, so each stall source is predicted from the cycle before it bites.
	// A late prediction would let one beat slip in while the lane slot is already lost.
	// An end block that is still owed holds ready low until it has gone out.
	// Software can also close the transmit side through the control word.
	wire tx_en = ctrl[CTRL_TX_EN];
	wire rx_en = ctrl[CTRL_RX_EN];
	wire accept = tx_tready & tx_tvalid;
	wire [NBW-1:0] tx_nfull = tx_nbytes >> 3;
	wire [2:0] tx_rem = tx_nbytes[2:0];
	wire next_gb_pause = (gb_cnt == GBW'(GB_PERIOD - 2)) | ~xcvr_gearbox_slot_ok;
	wire cc_start = (cc_timer == CCW'(CC_PERIOD - 1));
	wire cc_active = (cc_cnt != '0);
	wire next_cc_active = cc_start | (cc_cnt > CHW'(1));
	wire end_sent = end_pend & ~gb_pause & ~cc_active;
	wire end_set = accept & tx_tlast & (tx_nfull == NBW'(LANES));
	wire next_end_pend = channel_up & (end_set | (end_pend & ~end_sent));
	wire next_ready = channel_up & tx_en & ~next_gb_pause & ~next_cc_active & ~next_end_pend;

	// Valid bytes of the final beat are the ones in keep; keep counts only when last is high.
	// A keep with gaps would still be counted here, so the user must keep it contiguous.
	// Beats without last are treated as full words whatever keep shows.
	always_comb begin
		tx_nbytes = '0;
		for (int i = 0; i < WB; i++) begin
			tx_nbytes = tx_nbytes + NBW'(tx_tkeep[i]);
		end
	end

	// One block per lane per cycle; strict alignment puts data first, then end, then idles.
	// An end block carries its type in byte 0, the count in byte 1 and up to six bytes above.
	// Seven trailing bytes use the second end type, which has no count byte.
	// Compensation blocks fill the first three paused cycles; the rest of the pause is idle.
	// Lanes after the end lane are idle, so no data ever follows an end in one cycle.
	for (genvar j = 0; j < LANES; j++) begin : g_tx_lane
		wire [63:0] lane_in = tx_tdata[64*j +: 64];
		wire full_lane = ~tx_tlast | (NBW'(j) < tx_nfull);
		wire end_lane = tx_tlast & (NBW'(j) == tx_nfull);
		wire [63:0] end_word = {lane_in[47:0], 5'h00, tx_rem, BLK_END};
		wire [63:0] end7_word = {lane_in[55:0], BLK_END7};
		wire [63:0] idle_word = {56'h0, BLK_IDLE};
		wire [63:0] cc_word = {56'h0, BLK_CC};
		wire [63:0] empty_end = {48'h0, 8'h00, BLK_END};
		wire send_cc = cc_active & (cc_cnt > CHW'(CC_HOLD - CC_BLOCKS));
		wire send_data = ~cc_active & ~end_pend & accept & full_lane;
		wire send_end = ~cc_active & ~end_pend & accept & end_lane;
		wire send_pend = ~cc_active & end_pend & (j == 0);
		// Striping: lane j carries bytes 8j..8j+7 of the user word.
		assign next_blk_data[64*j +: 64] = send_cc ? cc_word :
			send_data ? lane_in :
			send_end ? ((tx_rem == 3'h7) ? end7_word : end_word) :
			send_pend ? empty_end :
			idle_word;
		assign next_blk_hdr[2*j +: 2] = send_data ? HDR_DATA : HDR_CTRL;
	end

	// Block outputs are registered; the gearbox pause cycle produces no block at all.
	// Data is still updated on the paused slot; only the valid flag marks it as unused.
	// The valid flag lags the ready-low cycle by one edge, matching the data pipeline.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_blk_data <= '0;
			tx_blk_hdr <= '0;
			tx_blk_valid <= 1'b0;
		end else begin
			tx_blk_data <= next_blk_data;
			tx_blk_hdr <= next_blk_hdr;
			tx_blk_valid <= channel_up & ~gb_pause;
		end
	end

	// Gearbox and compensation timers free-run so the pauses keep their fixed cadence.
	// They are not cleared when the channel drops, so the cadence stays tied to reset.
	// A pause on slot loss comes on top of the regular one and does not shift it.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			gb_cnt <= '0;
			gb_pause <= 1'b0;
			cc_timer <= '0;
			cc_cnt <= '0;
		end else begin
			gb_cnt <= gb_cnt + GBW'(1);
			gb_pause <= next_gb_pause;
			cc_timer <= cc_start ? '0 : cc_timer + CCW'(1);
			cc_cnt <= cc_start ? CHW'(CC_HOLD) : (cc_active ? cc_cnt - CHW'(1) : cc_cnt);
		end
	end

	// Ready is a flop, so every stall source is computed one cycle ahead.
	// The open-frame flag only feeds status; transfers do not depend on it.
	// Dropping the channel abandons any pending end block and any open frame.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_tready <= 1'b0;
			end_pend <= 1'b0;
			tx_open <= 1'b0;
		end else begin
			tx_tready <= next_ready;
			end_pend <= next_end_pend;
			if (!channel_up) begin
				tx_open <= 1'b0;
			end else if (accept) begin
				tx_open <= ~tx_tlast;
			end
		end
	end

	// Receive lanes: keep data and end blocks, drop idle and compensation blocks.
	// A count above six cannot fit and is clipped, so a corrupt count never grows the word.
	// Unknown control types are dropped like idles.
	for (genvar j = 0; j < LANES; j++) begin : g_rx_lane
		wire [63:0] rd = rx_blk_data[64*j +: 64];
		wire [1:0] rh = rx_blk_hdr[2*j +: 2];
		wire is_data = (rh == HDR_DATA);
		wire is_end = (rh == HDR_CTRL) & (rd[7:0] == BLK_END);
		wire is_end7 = (rh == HDR_CTRL) & (rd[7:0] == BLK_END7);
		wire [2:0] end_cnt = (rd[10:8] > 3'(END_MAX_BYTES)) ? 3'(END_MAX_BYTES) : rd[10:8];
		assign cur_data[64*j +: 64] = is_data ? rd :
			is_end ? {16'h0, rd[63:16]} :
			is_end7 ? {8'h0, rd[63:8]} :
			64'h0;
		assign lane_cnt[4*j +: 4] = is_data ? 4'h8 : is_end ? {1'b0, end_cnt} : is_end7 ? 4'h7 : 4'h0;
		assign lane_end[j] = is_end | is_end7;
	end

	// Bytes in this cycle's word, summed over the lanes.
	always_comb begin
		cur_bytes = '0;
		for (int j = 0; j < LANES; j++) begin
			cur_bytes = cur_bytes + NBW'(lane_cnt[4*j +: 4]);
		end
	end

	// A full word is held until the next word or end arrives, since only that tells whether it was the last.
	// This costs one cycle of latency but needs no second buffer.
	// An empty end with nothing held is ignored rather than producing a stray last.
	// Output strobes are gated with the channel so nothing leaks out while it is down.
	wire rx_live = rx_blk_valid & rx_en & channel_up;
	wire cur_present = rx_live & (cur_bytes != '0);
	wire cur_empty_end = rx_live & (|lane_end) & (cur_bytes == '0) & ~hold_last;
	wire emit = hold_valid & (hold_last | cur_empty_end | cur_present);
	wire emit_last = hold_last | cur_empty_end;
	wire emit_live = emit & channel_up;

	// Keep is all ones for a full word and a low-byte mask for a short final one.
	// The mask assumes bytes were filled from the low end, as on transmit.
	for (genvar i = 0; i < WB; i++) begin : g_rx_keep
		assign next_rx_keep[i] = ~emit_last | (NBW'(i) < hold_bytes);
	end

	// Hold stage: the only storage on receive; the user cannot stall it.
	// Loading a new word wins over draining, since the old one is emitted on the same edge.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_valid <= 1'b0;
			hold_last <= 1'b0;
			hold_bytes <= '0;
			hold_data <= '0;
		end else if (!channel_up) begin
			hold_valid <= 1'b0;
			hold_last <= 1'b0;
		end else if (cur_present) begin
			hold_valid <= 1'b1;
			hold_last <= |lane_end;
			hold_bytes <= cur_bytes;
			hold_data <= cur_data;
		end else if (emit) begin
			hold_valid <= 1'b0;
			hold_last <= 1'b0;
		end
	end

	// Receive outputs; valid simply drops on cycles that deliver nothing.
	// Last is gated with the channel as well, so it never appears without valid.
	// Data and keep follow the hold stage every cycle and mean nothing while valid is low.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_tvalid <= 1'b0;
			rx_tlast <= 1'b0;
			rx_tdata <= '0;
			rx_tkeep <= '0;
			rx_open <= 1'b0;
		end else begin
			rx_tvalid <= emit_live;
			rx_tlast <= emit_live & emit_last;
			rx_tdata <= hold_data;
			rx_tkeep <= next_rx_keep;
			if (!channel_up) begin
				rx_open <= 1'b0;
			end else if (emit) begin
				rx_open <= ~emit_last;
			end
		end
	end

	// Frame counters for software; they wrap silently.
	// Each counts a frame at the edge where its last beat is taken or given.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_frames <= '0;
			rx_frames <= '0;
		end else begin
			tx_frames <= tx_frames + 32'(accept & tx_tlast);
			rx_frames <= rx_frames + 32'(emit_live & emit_last);
		end
	end

	// APB decode; one wait state so read data comes from a flop.
	// Addresses that are not word aligned or lie outside the map answer with an error.
	// Byte lanes above the lowest are ignored, as the control word has only two bits.
	wire apb_req = psel & penable & ~pready;
	wire apb_done = psel & penable & pready;
	wire [7:0] reg_addr = 8'(paddr);
	wire addr_ok = (paddr[1:0] == 2'h0) & (APB_AW'(reg_addr) == paddr);
	wire hit_ctrl = addr_ok & (reg_addr == REG_CTRL);
	wire hit_stat = addr_ok & (reg_addr == REG_STATUS);
	wire hit_txf = addr_ok & (reg_addr == REG_TX_FRAMES);
	wire hit_rxf = addr_ok & (reg_addr == REG_RX_FRAMES);
	wire hit_any = hit_ctrl | hit_stat | hit_txf | hit_rxf;
	wire [31:0] stat_word = {27'h0, end_pend, cc_active, rx_open, tx_open, channel_up};
	wire [31:0] rd_mux = hit_ctrl ? ctrl :
		hit_stat ? stat_word :
		hit_txf ? tx_frames :
		hit_rxf ? rx_frames :
		32'h0;

	// Bus answer flops; a write to the control word lands only at the completing edge.
	// Read data is zero outside a read answer, which keeps the bus quiet between transfers.
	// Writes to status or counters complete without error and change nothing.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
			ctrl <= CTRL_RESET;
		end else begin
			pready <= apb_req;
			prdata <= (apb_req & ~pwrite) ? rd_mux : 32'h0;
			pslverr <= apb_req & ~hit_any;
			if (apb_done & pwrite & hit_ctrl & pstrb[0]) begin
				ctrl <= {30'h0, pwdata[CTRL_RX_EN], pwdata[CTRL_TX_EN]};
			end
		end
	end

	// The user side keeps its own byte order and termination; nothing here checks them.
	// Contiguous keep from the low byte is assumed by the popcount above.
	// No CRC is built into this variant, so keep and last come straight from the blocks.
endmodule : axis_frame_user_port

// *** verification/axis_frame_checks_asserts.sv ***
// Checker with port-level properties of the framing user port.
`timescale 1ns/1ps
module axis_frame_checks
	import axis_frame_pkg::*;
#(
	parameter int LANES = 1
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic channel_up,
	input wire logic xcvr_gearbox_slot_ok,
	input wire logic tx_tvalid,
	input wire logic tx_tlast,
	input wire logic [8*LANES-1:0] tx_tkeep,
	input wire logic tx_tready,
	input wire logic [64*LANES-1:0] tx_blk_data,
	input wire logic [2*LANES-1:0] tx_blk_hdr,
	input wire logic tx_blk_valid,
	input wire logic rx_tvalid,
	input wire logic rx_tlast,
	input wire logic [8*LANES-1:0] rx_tkeep
);
	logic [5:0] run;
	wire logic took;
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// A beat is taken only where both sides agree.
	assign took = tx_tready && tx_tvalid;
	// Length of the ready-high run; a missed gearbox pause lets it reach 32.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) run <= 6'h00;
		else run <= tx_tready ? run + 6'h01 : 6'h00;
	end
	a_gb_pause: assert property (run < 6'h20)
		else $error("ready ran past the pause");
	a_down_quiet: assert property (!channel_up |=> !tx_tready && !rx_tvalid)
		else $error("active while down");
	a_slot_yield: assert property (!xcvr_gearbox_slot_ok |=> !tx_tready ##1 !tx_blk_valid)
		else $error("slot loss not honoured");
	a_full_end: assert property (took && tx_tlast && tx_tkeep == '1 |=> !tx_tready)
		else $error("no pause for empty end");
	a_end_count: assert property (took && tx_tlast && tx_tkeep == 8'h0f |=>
		!tx_blk_valid || tx_blk_data[15:0] == {8'h04, BLK_END}) else $error("bad end block");
	a_gap_idle: assert property (tx_tready && !tx_tvalid |=>
		!tx_blk_valid || tx_blk_hdr[1:0] != HDR_DATA) else $error("data in a gap");
	a_rx_keep: assert property (rx_tvalid && !rx_tlast |-> rx_tkeep == '1)
		else $error("partial keep mid frame");
	a_rx_last: assert property (rx_tlast |-> rx_tvalid)
		else $error("last without valid");
	c_full: cover property (took && tx_tlast && tx_tkeep == '1);
	c_rx_last: cover property (rx_tvalid && rx_tlast);
	c_pause: cover property (tx_tready ##1 !tx_tready);
endmodule : axis_frame_checks
bind axis_frame_user_port axis_frame_checks #(.LANES(LANES)) u_checks (.sys_clk, .rst_n,
	.channel_up, .xcvr_gearbox_slot_ok, .tx_tvalid, .tx_tlast, .tx_tkeep, .tx_tready,
	.tx_blk_data, .tx_blk_hdr, .tx_blk_valid, .rx_tvalid, .rx_tlast, .rx_tkeep);

// *** verification/axis_frame_user_port_bench.sv ***
// Self-checking bench for the framing user port.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) miss("value mismatch"); end
module axis_frame_user_port_bench;
	import axis_frame_pkg::*;
	logic sys_clk, rst_n, channel_up, xcvr_gearbox_slot_ok, err;
	logic [63:0] tx_tdata, tx_blk_data, rx_blk_data, rx_tdata;
	logic tx_tvalid, tx_tlast, tx_tready, tx_blk_valid, rx_blk_valid, rx_tvalid, rx_tlast;
	logic [7:0] tx_tkeep, rx_tkeep, paddr;
	logic [1:0] tx_blk_hdr, rx_blk_hdr;
	logic psel, penable, pwrite, pready, pslverr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	int failures, num_checks, cc_seen;
	logic [65:0] txq[$];
	logic [72:0] rxq[$];
	wire logic ctl = tx_blk_valid && tx_blk_hdr == HDR_CTRL;
	axis_frame_user_port #(.CC_PERIOD(64)) u_axis_frame_user_port (.sys_clk, .rst_n,
		.channel_up, .xcvr_gearbox_slot_ok, .tx_tdata, .tx_tvalid, .tx_tlast, .tx_tkeep,
		.tx_tready, .tx_blk_data, .tx_blk_hdr, .tx_blk_valid, .rx_blk_data, .rx_blk_hdr,
		.rx_blk_valid, .rx_tdata, .rx_tvalid, .rx_tlast, .rx_tkeep, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr);
	user_stream_src u_user_stream_src (.sys_clk, .tx_tready, .tx_tdata, .tx_tvalid,
		.tx_tlast, .tx_tkeep);
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Idle and compensation blocks are left out so frames compare block by block.
	always @(posedge sys_clk) begin
		if (ctl && tx_blk_data[7:0] == BLK_CC) cc_seen++;
		else if (tx_blk_valid && !(ctl && tx_blk_data[7:0] == BLK_IDLE))
			txq.push_back({tx_blk_hdr, tx_blk_data});
		if (rx_tvalid) rxq.push_back({rx_tlast, rx_tkeep, rx_tdata});
	end
	task automatic miss(input string m);
		failures++;
		$display("unexpected %0t %s", $time, m);
	endtask : miss
	task automatic stop_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	// One APB transfer; the request is held until pready is seen at an edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (int k = 0; k < 16 && !pready; k++) @(posedge sys_clk);
		q = prdata;
		e = pslverr;
		if (!pready) miss("bus timed out");
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	task automatic rxb(input logic [1:0] h, input logic [63:0] d);
		rx_blk_hdr <= h;
		rx_blk_data <= d;
		rx_blk_valid <= 1'b1;
		@(posedge sys_clk);
	endtask : rxb
	task automatic t_regs;
		apb(1'b0, REG_CTRL, 32'h0, rd, err);
		`CHK(rd, CTRL_RESET)
		apb(1'b0, 8'h10, 32'h0, rd, err);
		`CHK(err, 1'b1)
		apb(1'b1, REG_CTRL, 32'h0, rd, err);
		@(posedge sys_clk);
		repeat (40) @(posedge sys_clk) `CHK(tx_tready, 1'b0)
		apb(1'b1, REG_CTRL, CTRL_RESET, rd, err);
	endtask : t_regs
	task automatic t_full;
		txq.delete();
		u_user_stream_src.send(3, 8'hff);
		repeat (16) @(posedge sys_clk);
		`CHK(txq.size(), 4)
		for (int i = 0; i < 3; i++) `CHK(txq[i], {HDR_DATA, {8{8'h10 + 8'(i)}}})
		`CHK({txq[3][65:64], txq[3][15:0]}, {HDR_CTRL, 8'h00, BLK_END})
		`CHK(cc_seen > 0, 1'b1)
	endtask : t_full
	task automatic t_part;
		txq.delete();
		u_user_stream_src.send(2, 8'h0f);
		repeat (16) @(posedge sys_clk);
		`CHK(txq.size(), 2)
		`CHK(txq[0], {HDR_DATA, {8{8'h10}}})
		`CHK(txq[1][65:64], HDR_CTRL)
		`CHK(txq[1][47:0], {32'h11111111, 5'h00, 3'h4, BLK_END})
		txq.delete();
		u_user_stream_src.send(1, 8'h7f);
		repeat (16) @(posedge sys_clk);
		`CHK(txq.size(), 1)
		`CHK(txq[0], {HDR_CTRL, 56'h10101010101010, BLK_END7})
		`CHK(u_user_stream_src.timeouts, 0)
		apb(1'b0, REG_TX_FRAMES, 32'h0, rd, err);
		`CHK(rd, 32'h3)
	endtask : t_part
	task automatic t_rx;
		rxq.delete();
		rxb(HDR_DATA, {8{8'ha0}});
		rxb(HDR_CTRL, {56'h0, BLK_IDLE});
		rxb(HDR_DATA, {8{8'ha1}});
		rxb(HDR_CTRL, {24'h0, 24'hc2c2c2, 8'h03, BLK_END});
		rxb(HDR_DATA, {8{8'ha2}});
		rxb(HDR_CTRL, {48'h0, 8'h00, BLK_END});
		rx_blk_valid <= 1'b0;
		rx_blk_data <= ~rx_blk_data;
		repeat (6) @(posedge sys_clk);
		`CHK(rxq.size(), 4)
		`CHK(rxq[3], {9'h1ff, {8{8'ha2}}})
		apb(1'b0, REG_RX_FRAMES, 32'h0, rd, err);
		`CHK(rd, 32'h2)
		`CHK(rxq[0], {9'h0ff, {8{8'ha0}}})
		`CHK(rxq[1], {9'h0ff, {8{8'ha1}}})
		`CHK({rxq[2][72:64], rxq[2][23:0]}, {9'h107, 24'hc2c2c2})
	endtask : t_rx
	task automatic t_down;
		xcvr_gearbox_slot_ok <= 1'b0;
		@(posedge sys_clk);
		xcvr_gearbox_slot_ok <= 1'b1;
		@(posedge sys_clk);
		`CHK(tx_tready, 1'b0)
		@(posedge sys_clk);
		`CHK(tx_blk_valid, 1'b0)
		channel_up <= 1'b0;
		repeat (3) @(posedge sys_clk);
		`CHK({tx_tready, rx_tvalid}, 2'b00)
		channel_up <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask : t_down
	initial begin
		{rst_n, psel, penable, pwrite, rx_blk_valid} = 5'h00;
		{channel_up, xcvr_gearbox_slot_ok, pstrb} = 6'h3f;
		{paddr, pwdata, rx_blk_data, rx_blk_hdr} = 106'h0;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_regs();
		t_full();
		t_part();
		t_rx();
		t_down();
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		miss("run timed out");
		stop_test();
	end
endmodule : axis_frame_user_port_bench

// *** verification/user_stream_src.sv ***
// Stream source model: the user logic that feeds frames to the transmit port.
`timescale 1ns/1ps
module user_stream_src (
	input wire logic sys_clk,
	input wire logic tx_tready,
	output logic [63:0] tx_tdata,
	output logic tx_tvalid,
	output logic tx_tlast,
	output logic [7:0] tx_tkeep
);
	// Beats that never see ready within the bound are counted for the bench to judge.
	int timeouts;
	// Nothing is offered until a frame is sent.
	initial begin
		timeouts = 0;
		tx_tdata = 64'h0;
		tx_tvalid = 1'b0;
		tx_tlast = 1'b0;
		tx_tkeep = 8'h00;
	end
	// Beat i carries bytes 0x10+i; a valid gap follows the first beat, with junk data on it.
	task automatic send(input int beats, input logic [7:0] last_keep);
		bit got;
		for (int i = 0; i < beats; i++) begin
			tx_tdata <= {8{8'h10 + 8'(i)}};
			tx_tvalid <= 1'b1;
			tx_tlast <= (i == beats - 1);
			tx_tkeep <= (i == beats - 1) ? last_keep : 8'hff;
			got = 1'b0;
			for (int k = 0; k < 64 && !got; k++) begin
				@(posedge sys_clk);
				got = tx_tready;
			end
			if (!got) timeouts++;
			if (i == 0) begin
				tx_tvalid <= 1'b0;
				tx_tdata <= ~tx_tdata;
				@(posedge sys_clk);
			end
		end
		tx_tvalid <= 1'b0;
		tx_tlast <= 1'b0;
		tx_tdata <= ~tx_tdata;
	endtask : send
endmodule : user_stream_src
